// ---- hdl/sdp_pkg.sv ----
`default_nettype none
package sdp_pkg;
    localparam int ADDR_W = 12;
    localparam int BANK_W = 2;
    localparam int BANK_N = 4;
    localparam int LANE_W = 8;
    localparam int AP_BIT = 10;
    localparam int MODE_BL_LSB = 0;
    localparam int MODE_BL_W = 3;
    localparam int MODE_CL_LSB = 4;
    localparam int MODE_CL_W = 3;
    localparam logic [2:0] BL_FULL = 3'h7;
    localparam logic [2:0] CL_3 = 3'h3;
    localparam logic [ADDR_W-1:0] MODE_RST = 12'h000;
    localparam logic [ADDR_W-1:0] CTL_MODE = 12'h020;
    localparam logic [1:0] CTL_RD_WAIT = 2'h2;
    localparam int FIFO_DEPTH = 4;
    localparam logic [3:0] CMD_MRS = 4'h0;
    localparam logic [3:0] CMD_REF = 4'h1;
    localparam logic [3:0] CMD_PRE = 4'h2;
    localparam logic [3:0] CMD_ACT = 4'h3;
    localparam logic [3:0] CMD_WR = 4'h4;
    localparam logic [3:0] CMD_RD = 4'h5;
    localparam logic [3:0] CMD_BST = 4'h6;
    localparam logic [3:0] CMD_NOP = 4'h7;
    typedef enum logic [2:0] {PWR_RUN, PWR_SUSPEND, PWR_PRE_PD, PWR_ACT_PD, PWR_SELF} sdp_pwr_t;
    typedef enum logic [2:0] {CT_INIT_PRE, CT_INIT_MRS, CT_IDLE, CT_RW, CT_WAIT, CT_LOWPWR,
                              CT_WAKE} sdp_ct_t;
endpackage : sdp_pkg
`default_nettype wire

// ---- hdl/sdp_if.sv ----
`timescale 1ns/100ps
`default_nettype none
interface sdp_if #(parameter int DQ_W = 16) ();
    logic              clk_enable;
    logic              chip_sel_n;
    logic              row_strobe_n;
    logic              col_strobe_n;
    logic              wr_enable_n;
    logic              bank_select_0;
    logic              bank_select_1;
    logic              lower_byte_mask;
    logic              upper_byte_mask;
    logic [11:0]       address_bus;
    logic [DQ_W-1:0]   ctl_dq_out;
    logic [DQ_W-1:0]   ctl_dq_oe_n;
    logic [DQ_W-1:0]   dev_dq_out;
    logic [DQ_W-1:0]   dev_dq_oe_n;
    logic [DQ_W-1:0]   data_bus;

    // An undriven bit reads as zero; the two ends never drive together in normal use.
    for (genvar i = 0; i < DQ_W; i++)
    begin : g_wire
        assign data_bus[i] = !dev_dq_oe_n[i] ? dev_dq_out[i] :
                             (!ctl_dq_oe_n[i] ? ctl_dq_out[i] : 1'b0);
    end

    modport dev (input clk_enable, chip_sel_n, row_strobe_n, col_strobe_n, wr_enable_n,
                 bank_select_0, bank_select_1, lower_byte_mask, upper_byte_mask,
                 address_bus, data_bus, output dev_dq_out, dev_dq_oe_n);
    modport ctl (output clk_enable, chip_sel_n, row_strobe_n, col_strobe_n, wr_enable_n,
                 bank_select_0, bank_select_1, lower_byte_mask, upper_byte_mask,
                 address_bus, ctl_dq_out, ctl_dq_oe_n, input data_bus);
endinterface : sdp_if
`default_nettype wire

// ---- hdl/sdp_device.sv ----
// Function
// - Sample all inputs on rising clock only.
// - Each clock advances burst and output registers.
// - Clock enable high activates, low deactivates clock.
// - Low enable enters power-down, self refresh, suspend.
// - Clock enable asynchronous while powered down; model samples it on rising clock.
// - Input buffers off in power-down, self refresh.
// - Controller may tie clock enable high.
// - Chip select low enables decoder, high ignores.
// - Bursts and masks continue while deselected.
// - Select plus three strobes encode the command.
// - Masked byte lanes are not written.
// - Read mask turns drivers off two clocks later.
// - Lower mask low byte, upper mask high byte.
// - Bank selects pick the target bank.
// - Activate captures twelve-bit row address.
// - Read/write column width depends on organization.
// - Address bit ten selects auto precharge.
// - Precharge bit ten high closes all banks.
// - Mode load writes address into mode register.
// - Access starts with activate, then read/write.
`timescale 1ns/100ps
`default_nettype none
module sdp_device
    import sdp_pkg::*;
#(
    parameter int DQ_W   = 16,
    parameter int MEM_AW = 6
)
(
    input  wire logic               core_clk,
    input  wire logic               rstn,
    sdp_if.dev                      link,
    output var logic [ADDR_W-1:0]   mode_reg,
    output var logic [BANK_N-1:0]   open_banks,
    output var logic                low_power
);
    localparam int COL_W    = (DQ_W == 4) ? 10 : ((DQ_W == 8) ? 9 : 8);
    localparam int ROW_KEEP = MEM_AW - BANK_W - 3;

    sdp_pwr_t              pwr_ff;
    logic [ADDR_W-1:0]     mode_ff;
    logic [BANK_N-1:0]     open_ff;
    logic [ADDR_W-1:0]     row_ff [BANK_N];
    logic                  low_power_ff;
    logic                  burst_ff;
    logic                  wr_ff;
    logic                  ap_ff;
    logic [BANK_W-1:0]     bank_ff;
    logic [COL_W-1:0]      col_ff;
    logic [COL_W-1:0]      cnt_ff;
    logic [DQ_W-1:0]       mem_ff [2**MEM_AW];
    logic [DQ_W-1:0]       pipe0_ff;
    logic [DQ_W-1:0]       pipe1_ff;
    logic                  pv0_ff;
    logic                  pv1_ff;
    logic [DQ_W-1:0]       dq_out_ff;
    logic [DQ_W-1:0]       oe_n_ff;
    logic [DQ_W-1:0]       dqm_d1_ff;
    logic [3:0]            cmd;
    logic [BANK_W-1:0]     bank_in;
    logic                  clk_act;
    logic                  start;
    logic                  acc_on;
    logic                  acc_wr;
    logic                  done;
    logic                  done_ap;
    logic [BANK_W-1:0]     acc_bank;
    logic [COL_W-1:0]      acc_col;
    logic [COL_W-1:0]      bl_last;
    logic [COL_W-1:0]      nxt_col;
    logic [MEM_AW-1:0]     idx;
    logic [DQ_W-1:0]       bit_mask;
    logic                  cl3;
    logic [DQ_W-1:0]       rd_src;
    logic                  rd_src_v;

    // A deselected cycle decodes as no operation.
    assign cmd = link.chip_sel_n ? CMD_NOP :
                 {1'b0, link.row_strobe_n, link.col_strobe_n, link.wr_enable_n};
    assign bank_in = {link.bank_select_1, link.bank_select_0};
    // Inputs are ignored whenever the internal clock is stopped.
    assign clk_act = (pwr_ff == PWR_RUN);

    for (genvar i = 0; i < DQ_W; i++)
    begin : g_mask
        if (DQ_W == 16 && i < LANE_W)
        begin : g_low
            assign bit_mask[i] = link.lower_byte_mask;
        end
        else
        begin : g_up
            assign bit_mask[i] = link.upper_byte_mask;
        end
    end

    always_comb
    begin
        bl_last = '0;
        if (mode_ff[MODE_BL_LSB +: MODE_BL_W] == BL_FULL)
            bl_last = '1;
        else if (!mode_ff[MODE_BL_LSB + 2])
            bl_last = COL_W'((1 << mode_ff[MODE_BL_LSB +: 2]) - 1);
    end

    assign cl3      = (mode_ff[MODE_CL_LSB +: MODE_CL_W] == CL_3);
    assign start    = clk_act && (cmd == CMD_RD || cmd == CMD_WR);
    assign acc_on   = start || (clk_act && burst_ff && cmd != CMD_BST);
    assign acc_wr   = start ? (cmd == CMD_WR) : wr_ff;
    assign acc_bank = start ? bank_in : bank_ff;
    assign acc_col  = start ? link.address_bus[COL_W-1:0] : col_ff;
    // The burst wraps inside its own aligned block of columns.
    assign nxt_col  = (acc_col & ~bl_last) | ((acc_col + COL_W'(1)) & bl_last);
    assign done     = (start && bl_last == '0) ||
                      (clk_act && burst_ff && !start && cmd != CMD_BST && cnt_ff == bl_last);
    assign done_ap  = start ? link.address_bus[AP_BIT] : ap_ff;
    // Only a few row bits index the small array, so distinct rows may alias.
    assign idx = {acc_bank, row_ff[acc_bank][ROW_KEEP-1:0], acc_col[2:0]};

    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
            pwr_ff <= PWR_RUN;
        else
        begin
            case (pwr_ff)
                PWR_RUN:
                    if (!link.clk_enable)
                    begin
                        if (burst_ff)
                            pwr_ff <= PWR_SUSPEND;
                        else if (cmd == CMD_REF)
                            pwr_ff <= PWR_SELF;
                        else if (|open_ff)
                            pwr_ff <= PWR_ACT_PD;
                        else
                            pwr_ff <= PWR_PRE_PD;
                    end
                PWR_SUSPEND:
                    if (link.clk_enable)
                        pwr_ff <= PWR_RUN;
                default:
                    // Clock enable is watched directly here; all other inputs stay gated.
                    if (link.clk_enable)
                        pwr_ff <= PWR_RUN;
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
            low_power_ff <= 1'b0;
        else
            low_power_ff <= (pwr_ff != PWR_RUN) && (pwr_ff != PWR_SUSPEND);
    end

    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
            mode_ff <= MODE_RST;
        else if (clk_act && cmd == CMD_MRS)
            mode_ff <= link.address_bus;
    end

    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            open_ff <= '0;
            for (int b = 0; b < BANK_N; b++)
                row_ff[b] <= '0;
        end
        else if (clk_act)
        begin
            if (done && done_ap)
                open_ff[acc_bank] <= 1'b0;
            if (cmd == CMD_ACT)
            begin
                open_ff[bank_in] <= 1'b1;
                row_ff[bank_in]  <= link.address_bus;
            end
            else if (cmd == CMD_PRE)
            begin
                if (link.address_bus[AP_BIT])
                    open_ff <= '0;
                else
                    open_ff[bank_in] <= 1'b0;
            end
        end
    end

    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            burst_ff <= 1'b0;
            wr_ff    <= 1'b0;
            ap_ff    <= 1'b0;
            bank_ff  <= '0;
            col_ff   <= '0;
            cnt_ff   <= '0;
        end
        else if (start)
        begin
            burst_ff <= (bl_last != '0);
            wr_ff    <= (cmd == CMD_WR);
            ap_ff    <= link.address_bus[AP_BIT];
            bank_ff  <= bank_in;
            col_ff   <= nxt_col;
            cnt_ff   <= COL_W'(1);
        end
        else if (clk_act && burst_ff)
        begin
            if (cmd == CMD_BST || done)
                burst_ff <= 1'b0;
            col_ff <= nxt_col;
            cnt_ff <= cnt_ff + COL_W'(1);
        end
    end

    always_ff @(posedge core_clk)
    begin
        // Masked bits keep their old value.
        if (acc_on && acc_wr)
            mem_ff[idx] <= (mem_ff[idx] & bit_mask) | (link.data_bus & ~bit_mask);
    end

    assign rd_src   = cl3 ? pipe1_ff : pipe0_ff;
    assign rd_src_v = cl3 ? pv1_ff : pv0_ff;

    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            pipe0_ff  <= '0;
            pipe1_ff  <= '0;
            pv0_ff    <= 1'b0;
            pv1_ff    <= 1'b0;
            dq_out_ff <= '0;
            oe_n_ff   <= '1;
            dqm_d1_ff <= '0;
        end
        else if (clk_act)
        begin
            pipe0_ff  <= mem_ff[idx];
            pv0_ff    <= acc_on && !acc_wr;
            pipe1_ff  <= pipe0_ff;
            pv1_ff    <= pv0_ff;
            dq_out_ff <= rd_src;
            dqm_d1_ff <= bit_mask;
            oe_n_ff   <= ~({DQ_W{rd_src_v}} & ~dqm_d1_ff);
        end
        else if (pwr_ff != PWR_SUSPEND)
        begin
            // Suspend freezes the outputs; a stopped device releases the bus.
            pv0_ff  <= 1'b0;
            pv1_ff  <= 1'b0;
            oe_n_ff <= '1;
        end
    end

    assign link.dev_dq_out  = dq_out_ff;
    assign link.dev_dq_oe_n = oe_n_ff;
    assign mode_reg         = mode_ff;
    assign open_banks       = open_ff;
    assign low_power        = low_power_ff;
endmodule : sdp_device
`default_nettype wire

// ---- hdl/sdp_ctrl.sv ----
`timescale 1ns/100ps
`default_nettype none
module sdp_fifo #(
    parameter int W     = 16,
    parameter int DEPTH = 4
)
(
    input  wire logic            core_clk,
    input  wire logic            rstn,
    input  wire logic            in_valid,
    output var logic             in_ready,
    input  wire logic [W-1:0]    in_data,
    output var logic             out_valid,
    input  wire logic            out_ready,
    output var logic [W-1:0]     out_data
);
    localparam int PW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH + 1);

    logic [W-1:0]   mem_ff [DEPTH];
    logic [PW-1:0]  wr_ff;
    logic [PW-1:0]  rd_ff;
    logic [CW-1:0]  cnt_ff;
    logic [CW-1:0]  nxt_cnt;
    logic           in_ready_ff;
    logic           out_valid_ff;
    logic           push;
    logic           pop;

    assign push    = in_valid && in_ready_ff;
    assign pop     = out_ready && out_valid_ff;
    assign nxt_cnt = cnt_ff + CW'(push) - CW'(pop);

    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            wr_ff        <= '0;
            rd_ff        <= '0;
            cnt_ff       <= '0;
            in_ready_ff  <= 1'b1;
            out_valid_ff <= 1'b0;
        end
        else
        begin
            if (push)
                wr_ff <= PW'(wr_ff + PW'(1));
            if (pop)
                rd_ff <= PW'(rd_ff + PW'(1));
            cnt_ff       <= nxt_cnt;
            in_ready_ff  <= (nxt_cnt != CW'(DEPTH));
            out_valid_ff <= (nxt_cnt != '0);
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (push)
            mem_ff[wr_ff] <= in_data;
    end

    assign in_ready  = in_ready_ff;
    assign out_valid = out_valid_ff;
    assign out_data  = mem_ff[rd_ff];
endmodule : sdp_fifo

module sdp_ctrl
    import sdp_pkg::*;
#(
    parameter int DQ_W = 16
)
(
    input  wire logic               core_clk,
    input  wire logic               rstn,
    sdp_if.ctl                      link,
    input  wire logic               req_valid,
    output var logic                req_ready,
    input  wire logic               req_write,
    input  wire logic [BANK_W-1:0]  req_bank,
    input  wire logic [ADDR_W-1:0]  req_row,
    input  wire logic [ADDR_W-1:0]  req_col,
    input  wire logic [DQ_W-1:0]    req_wdata,
    input  wire logic [1:0]         req_wmask,
    output var logic                rd_valid,
    input  wire logic               rd_ready,
    output var logic [DQ_W-1:0]     rd_data,
    input  wire logic               pd_req,
    input  wire logic               sr_req,
    output var logic                init_done
);
    sdp_ct_t            st_ff;
    logic               cke_ff;
    logic [3:0]         cmd_ff;
    logic [BANK_W-1:0]  ba_ff;
    logic [ADDR_W-1:0]  addr_ff;
    logic [1:0]         mask_ff;
    logic [DQ_W-1:0]    dq_ff;
    logic [DQ_W-1:0]    oe_n_ff;
    logic               ready_ff;
    logic               done_ff;
    logic               wr_ff;
    logic [1:0]         wait_ff;
    logic [ADDR_W-1:0]  col_ff;
    logic [DQ_W-1:0]    wdata_ff;
    logic [1:0]         wmask_ff;
    logic               fifo_ready;
    logic               push;

    assign push = (st_ff == CT_WAIT) && !wr_ff && (wait_ff == '0);

    sdp_fifo #(.W(DQ_W), .DEPTH(FIFO_DEPTH)) u_fifo (
        .core_clk  (core_clk),
        .rstn      (rstn),
        .in_valid  (push),
        .in_ready  (fifo_ready),
        .in_data   (link.data_bus),
        .out_valid (rd_valid),
        .out_ready (rd_ready),
        .out_data  (rd_data)
    );

    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            st_ff    <= CT_INIT_PRE;
            cke_ff   <= 1'b1;
            cmd_ff   <= CMD_NOP;
            ba_ff    <= '0;
            addr_ff  <= '0;
            mask_ff  <= '0;
            dq_ff    <= '0;
            oe_n_ff  <= '1;
            ready_ff <= 1'b0;
            done_ff  <= 1'b0;
            wr_ff    <= 1'b0;
            wait_ff  <= '0;
            col_ff   <= '0;
            wdata_ff <= '0;
            wmask_ff <= '0;
        end
        else
        begin
            cmd_ff  <= CMD_NOP;
            oe_n_ff <= '1;
            mask_ff <= '0;
            case (st_ff)
                CT_INIT_PRE:
                begin
                    cmd_ff          <= CMD_PRE;
                    addr_ff[AP_BIT] <= 1'b1;
                    st_ff           <= CT_INIT_MRS;
                end
                CT_INIT_MRS:
                begin
                    cmd_ff  <= CMD_MRS;
                    ba_ff   <= '0;
                    addr_ff <= CTL_MODE;
                    done_ff <= 1'b1;
                    st_ff   <= CT_IDLE;
                end
                CT_IDLE:
                    if (req_valid && ready_ff)
                    begin
                        cmd_ff   <= CMD_ACT;
                        ba_ff    <= req_bank;
                        addr_ff  <= req_row;
                        wr_ff    <= req_write;
                        col_ff   <= req_col;
                        wdata_ff <= req_wdata;
                        wmask_ff <= req_wmask;
                        ready_ff <= 1'b0;
                        st_ff    <= CT_RW;
                    end
                    else if (sr_req || pd_req)
                    begin
                        if (sr_req)
                            cmd_ff <= CMD_REF;
                        cke_ff   <= 1'b0;
                        ready_ff <= 1'b0;
                        st_ff    <= CT_LOWPWR;
                    end
                    else
                        ready_ff <= fifo_ready;
                CT_RW:
                begin
                    // Every access closes its row again, so each request reopens it.
                    cmd_ff          <= wr_ff ? CMD_WR : CMD_RD;
                    addr_ff         <= col_ff;
                    addr_ff[AP_BIT] <= 1'b1;
                    if (wr_ff)
                    begin
                        dq_ff   <= wdata_ff;
                        oe_n_ff <= '0;
                        mask_ff <= wmask_ff;
                    end
                    wait_ff <= wr_ff ? 2'h0 : CTL_RD_WAIT;
                    st_ff   <= CT_WAIT;
                end
                CT_WAIT:
                    // Ready is left to idle, where the FIFO's space already counts this push.
                    if (wait_ff == '0)
                        st_ff <= CT_IDLE;
                    else
                        wait_ff <= wait_ff - 2'h1;
                CT_LOWPWR:
                    if (!sr_req && !pd_req)
                    begin
                        cke_ff <= 1'b1;
                        st_ff  <= CT_WAKE;
                    end
                default:
                    st_ff <= CT_IDLE;
            endcase
        end
    end

    assign link.clk_enable      = cke_ff;
    assign link.chip_sel_n      = cmd_ff[3];
    assign link.row_strobe_n    = cmd_ff[2];
    assign link.col_strobe_n    = cmd_ff[1];
    assign link.wr_enable_n     = cmd_ff[0];
    assign link.bank_select_0   = ba_ff[0];
    assign link.bank_select_1   = ba_ff[1];
    assign link.address_bus     = addr_ff;
    assign link.lower_byte_mask = mask_ff[0];
    assign link.upper_byte_mask = mask_ff[1];
    assign link.ctl_dq_out      = dq_ff;
    assign link.ctl_dq_oe_n     = oe_n_ff;
    assign req_ready            = ready_ff;
    assign init_done            = done_ff;
endmodule : sdp_ctrl
`default_nettype wire

// ---- hdl/sdp_wake_note.sv ----
`timescale 1ns/100ps
`default_nettype none
`default_nettype wire

// ---- test/sdp_checker.sv ----
`timescale 1ns/100ps
`default_nettype none
module sdp_checker
    import sdp_pkg::*;
#(
    parameter int DQ_W = 16
)
(
    input  wire logic              core_clk,
    input  wire logic              rstn,
    input  wire logic              clk_enable,
    input  wire logic              chip_sel_n,
    input  wire logic              row_strobe_n,
    input  wire logic              col_strobe_n,
    input  wire logic              wr_enable_n,
    input  wire logic              bank_select_0,
    input  wire logic              bank_select_1,
    input  wire logic              lower_byte_mask,
    input  wire logic              upper_byte_mask,
    input  wire logic [11:0]       address_bus,
    input  wire logic [DQ_W-1:0]   dev_dq_oe_n
);
    logic [3:0] cmd;
    logic       access;
    assign cmd = {chip_sel_n, row_strobe_n, col_strobe_n, wr_enable_n};
    assign access = (cmd == CMD_RD) || (cmd == CMD_WR);

    default clocking dc @(posedge core_clk);
    endclocking
    default disable iff (!rstn);

    // Suspend freezes the output pipe, so each window demands a running clock throughout.
    chk_read_slot_open: assert property ((cmd == CMD_RD && !lower_byte_mask && !upper_byte_mask
        && clk_enable && $past(clk_enable)) ##1 clk_enable |=> dev_dq_oe_n == '0)
        else $error("read word not driven two cycles after the read");
    chk_upper_mask_hiz: assert property (upper_byte_mask && clk_enable ##1 clk_enable
        |=> dev_dq_oe_n[DQ_W-1:8] == '1) else $error("upper lane driven despite its mask");
    chk_lower_mask_hiz: assert property (lower_byte_mask && clk_enable ##1 clk_enable
        |=> dev_dq_oe_n[7:0] == '1) else $error("lower lane driven despite its mask");
    chk_stray_drive: assert property (dev_dq_oe_n != '1 && $past(clk_enable)
        |-> $past(cmd, 2) == CMD_RD) else $error("data driven without a read two cycles before");
    chk_act_first: assert property (access |-> $past(cmd) == CMD_ACT
        && $past({bank_select_1, bank_select_0}) == {bank_select_1, bank_select_0})
        else $error("access without an activate to the same bank");
    chk_auto_close: assert property (access |-> address_bus[AP_BIT])
        else $error("access issued without auto precharge");
    chk_wake_nop: assert property ($rose(clk_enable) |-> cmd == CMD_NOP)
        else $error("command issued on the wake-up edge");
    chk_init_order: assert property ($rose(rstn) |=> cmd == CMD_PRE && address_bus[AP_BIT]
        ##1 cmd == CMD_MRS && address_bus == CTL_MODE) else $error("bad start-up sequence");
    chk_power_quiet: assert property (!clk_enable && !$past(clk_enable) |-> dev_dq_oe_n == '1)
        else $error("data driven while stopped");

    cov_read: cover property (cmd == CMD_RD);
    cov_masked_write: cover property (cmd == CMD_WR && upper_byte_mask);
    cov_stop: cover property ($fell(clk_enable));
endmodule : sdp_checker
`default_nettype wire

// ---- test/sdp_bench.sv ----
`timescale 1ns/100ps
`default_nettype none
module sdp_bench
    import sdp_pkg::*;
;
    typedef struct packed {
        logic        wr;
        logic [1:0]  bank;
        logic [11:0] row;
        logic [11:0] col;
        logic [15:0] data;
        logic [1:0]  mask;
    } sdp_row_t;

    logic        core_clk, rstn, req_valid, req_ready, req_write, rd_valid, rd_ready;
    logic        pd_req, sr_req, init_done, low_power;
    logic [1:0]  req_bank, req_wmask;
    logic [11:0] req_row, req_col, mode_reg;
    logic [15:0] req_wdata, rd_data;
    logic [3:0]  open_banks;
    int          errors, comparisons, cycles;

    // Data of a read row is the word expected back; mask bit 1 guards the upper lane.
    sdp_row_t rows [8] = '{
        {1'b1, 2'h0, 12'h000, 12'h001, 16'h1234, 2'h0}, {1'b0, 2'h0, 12'h000, 12'h001, 16'h1234, 2'h0},
        {1'b1, 2'h0, 12'h000, 12'h001, 16'habcd, 2'h1}, {1'b1, 2'h1, 12'h000, 12'h001, 16'h7777, 2'h0},
        {1'b0, 2'h0, 12'h000, 12'h001, 16'hab34, 2'h0}, {1'b1, 2'h3, 12'h001, 12'h007, 16'h5a5a, 2'h0},
        {1'b1, 2'h3, 12'h001, 12'h007, 16'hffff, 2'h2}, {1'b0, 2'h3, 12'h001, 12'h007, 16'h5aff, 2'h0}};

    sdp_if #(.DQ_W(16)) link ();
    sdp_device #(.DQ_W(16), .MEM_AW(6)) u_sdp_device (.core_clk, .rstn, .link(link), .mode_reg,
        .open_banks, .low_power);
    sdp_ctrl #(.DQ_W(16)) u_sdp_ctrl (.core_clk, .rstn, .link(link), .req_valid, .req_ready,
        .req_write, .req_bank, .req_row, .req_col, .req_wdata, .req_wmask, .rd_valid, .rd_ready,
        .rd_data, .pd_req, .sr_req, .init_done);
    sdp_checker #(.DQ_W(16)) u_sdp_checker (.core_clk, .rstn, .clk_enable(link.clk_enable),
        .chip_sel_n(link.chip_sel_n), .row_strobe_n(link.row_strobe_n),
        .col_strobe_n(link.col_strobe_n), .wr_enable_n(link.wr_enable_n),
        .bank_select_0(link.bank_select_0), .bank_select_1(link.bank_select_1),
        .lower_byte_mask(link.lower_byte_mask), .upper_byte_mask(link.upper_byte_mask),
        .address_bus(link.address_bus), .dev_dq_oe_n(link.dev_dq_oe_n));

    initial
    begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end

    task automatic tally_and_finish;
        if (errors == 0 && comparisons > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : tally_and_finish

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            errors++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check

    // The request is held from a falling edge until the rising edge that takes it.
    task automatic issue(input sdp_row_t r);
        @(negedge core_clk);
        req_valid = 1'b1;
        {req_write, req_bank, req_row, req_col, req_wdata, req_wmask} = r;
        while (req_ready !== 1'b1)
            @(negedge core_clk);
        @(negedge core_clk);
        req_valid = 1'b0;
    endtask : issue

    task automatic take(input logic [15:0] exp);
        while (rd_valid !== 1'b1)
            @(negedge core_clk);
        check(rd_data, exp);
        @(negedge core_clk);
    endtask : take

    always @(posedge core_clk)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            errors++;
            tally_and_finish;
        end
    end

    initial
    begin
        rstn = 1'b0;
        req_valid = 1'b0;
        {req_write, req_bank, req_row, req_col, req_wdata, req_wmask} = '0;
        rd_ready = 1'b1;
        {sr_req, pd_req} = 2'h0;
        repeat (3) @(negedge core_clk);
        check(link.dev_dq_oe_n, 16'hffff);
        check({15'h0, link.clk_enable}, 16'h1);
        check({15'h0, init_done}, 16'h0);
        rstn = 1'b1;
        foreach (rows[i])
        begin
            issue(rows[i]);
            if (!rows[i].wr)
                take(rows[i].data);
        end
        check({4'h0, mode_reg}, {4'h0, CTL_MODE});
        check({15'h0, init_done}, 16'h1);
        check({12'h0, open_banks}, 16'h0);
        // Stall the reader so the FIFO fills and further requests are refused.
        rd_ready = 1'b0;
        for (int i = 0; i < 4; i++)
            issue(rows[(i % 2) ? 7 : 4]);
        repeat (8) @(negedge core_clk);
        check({15'h0, req_ready}, 16'h0);
        rd_ready = 1'b1;
        for (int i = 0; i < 4; i++)
            take(rows[(i % 2) ? 7 : 4].data);
        check({15'h0, rd_valid}, 16'h0);
        for (int m = 0; m < 2; m++)
        begin
            {sr_req, pd_req} = m ? 2'h2 : 2'h1;
            while (low_power !== 1'b1)
                @(negedge core_clk);
            check({15'h0, link.clk_enable}, 16'h0);
            check(link.dev_dq_oe_n, 16'hffff);
            {sr_req, pd_req} = 2'h0;
            while (low_power !== 1'b0)
                @(negedge core_clk);
            issue(rows[7]);
            take(rows[7].data);
        end
        tally_and_finish;
    end
endmodule : sdp_bench
`default_nettype wire
